// ==== src/mmu_cfg_pkg.sv ====
// Constants, encodings and carriers shared by the MMU configuration unit
package mmu_cfg_pkg;
  localparam logic [7:0] CTRL_OFS = 8'h00;
  localparam logic [7:0] STAT_OFS = 8'h04;
  localparam logic [7:0] CAUSE_OFS = 8'h08;
  localparam int LVL_LSB = 0;
  localparam int ACC_LSB = 2;
  localparam int POL_LSB = 4;
  localparam int ZN_LSB = 8;
  localparam int STAT_EN_LSB = 2;
  localparam int STAT_PID_LSB = 8;
  localparam int STAT_IDX_LSB = 16;
  localparam logic [1:0] LVL_RST = 2'h0;
  localparam logic [1:0] ACC_RST = 2'h3;
  localparam logic [1:0] POL_RST = 2'h0;
  localparam logic [4:0] ZN_RST = 5'h10;
  localparam int MAX_ZONES = 16;
  localparam int DTLB_ENTRIES = 4;
  localparam int ITLB_ENTRIES = 2;
  localparam int MAIN_ENTRIES = 16;
  localparam int PAGE_LSB = 10;
  localparam int HI_VALID_BIT = 6;
  localparam int LO_EX_BIT = 9;
  localparam int LO_WR_BIT = 8;
  localparam int LO_ZONE_LSB = 4;
  localparam int EXC_PRIV = 0;
  localparam int EXC_DSTOR = 1;
  localparam int EXC_ISTOR = 2;
  localparam int EXC_DMISS = 3;
  localparam int EXC_IMISS = 4;

  typedef enum logic [1:0] {
    LVL_NONE = 2'h0, LVL_USER = 2'h1, LVL_PROT = 2'h2, LVL_VIRT = 2'h3
  } level_e;
  typedef enum logic [1:0] {
    ACC_MIN = 2'h0, ACC_READ = 2'h1, ACC_WRITE = 2'h2, ACC_FULL = 2'h3
  } access_e;
  typedef enum logic [2:0] {
    SPR_LO = 3'h0, SPR_HI = 3'h1, SPR_IDX = 3'h2, SPR_PID = 3'h3,
    SPR_ZPR = 3'h4
  } spr_sel_e;
  typedef enum logic [1:0] {
    CLS_PLAIN = 2'h0, CLS_PRIV = 2'h1, CLS_STREAM = 2'h2, CLS_EXT = 2'h3
  } instr_cls_e;

  typedef struct packed {
    logic valid;
    logic [21:0] vpn;
    logic [21:0] rpn;
    logic [3:0] zone;
    logic wr;
    logic ex;
  } tlb_entry_s;
  typedef struct packed {
    logic valid;
    logic write;
    logic user;
    logic [31:0] vaddr;
  } xlat_req_s;
  typedef struct packed {
    logic done;
    logic miss;
    logic [31:0] paddr;
  } xlat_rsp_s;
  typedef struct packed {
    logic valid;
    logic write;
    spr_sel_e sel;
    logic [31:0] wdata;
  } spr_req_s;
  typedef struct packed {
    logic done;
    logic ok;
    logic [31:0] rdata;
  } spr_rsp_s;
  typedef struct packed {
    logic valid;
    logic user;
    instr_cls_e cls;
  } instr_s;
endpackage

// ==== src/shadow_tlb.sv ====
// Small shadow TLB caching translations in front of the main TLB
`timescale 1ns/1ps
module shadow_tlb #(
  parameter int ENTRIES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic flush,
  input wire logic bypass,
  input wire logic translate,
  input wire mmu_cfg_pkg::xlat_req_s req,
  input wire logic main_hit,
  input wire mmu_cfg_pkg::tlb_entry_s main_entry,
  output mmu_cfg_pkg::xlat_rsp_s rsp,
  output mmu_cfg_pkg::tlb_entry_s rsp_entry
);
  localparam int PW = (ENTRIES > 1) ? $clog2(ENTRIES) : 1;
  mmu_cfg_pkg::tlb_entry_s ent [ENTRIES];
  logic [PW-1:0] fill_ptr;
  logic shadow_hit;
  mmu_cfg_pkg::tlb_entry_s pick;
  logic [21:0] vpn;

  assign vpn = req.vaddr[31:mmu_cfg_pkg::PAGE_LSB];

  always_comb begin
    shadow_hit = 1'b0;
    pick = main_entry;
    for (int i = 0; i < ENTRIES; i++) begin
      if (ent[i].valid && ent[i].vpn == vpn && !shadow_hit) begin
        shadow_hit = 1'b1;
        pick = ent[i];
      end
    end
  end

  // Refill on a shadow miss that the main TLB resolves
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      fill_ptr <= '0;
      for (int i = 0; i < ENTRIES; i++) ent[i] <= '0;
    end else if (flush) begin
      for (int i = 0; i < ENTRIES; i++) ent[i].valid <= 1'b0;
    end else if (req.valid && !bypass && !shadow_hit && main_hit) begin
      ent[fill_ptr] <= main_entry;
      fill_ptr <= (fill_ptr == PW'(ENTRIES - 1)) ? '0 : fill_ptr + 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rsp <= '0;
      rsp_entry <= '0;
    end else begin
      rsp.done <= req.valid;
      rsp.miss <= req.valid && !bypass && !shadow_hit && !main_hit;
      rsp_entry <= pick;
      if (bypass || !translate)
        rsp.paddr <= req.vaddr;
      else
        rsp.paddr <= {pick.rpn, req.vaddr[mmu_cfg_pkg::PAGE_LSB-1:0]};
    end
  end
endmodule

// ==== src/mmu_privilege_config.sv ====
// MMU level, special register gating and user-mode privilege checking
// Functional notes
// RULE1: level register resets to 0, disabling all management and checks
// RULE2: level 1 gives user/privileged split only, no protection or mapping
// RULE3: level 2 adds zone protection to the user/privileged split
// RULE4: level 3 adds virtual to physical address translation
// RULE5: level 1 enables the privileged instruction exception
// RULE6: levels 2 and 3 enable privileged plus four memory exceptions
// RULE7: data shadow TLB caches data translations, four entries by default
// RULE8: instruction shadow TLB caches fetch translations, two entries default
// RULE9: special registers reached only by move-to/from, gated by access level; the status register also returns index and process id over APB
// RULE10: access level 0 permits only writes of low, high and index
// RULE11: access level 1 adds reads of low, high, index, process id, zones
// RULE12: access level 2 writes every register, reads only the index
// RULE13: access level 3 writes all and reads low, high, index, id, zones
// RULE14: implemented zone count is configurable from zero to sixteen
// RULE15: policy 0 makes stream and extended-address instructions privileged
// RULE16: policy 1 lets stream instructions run in user mode
// RULE17: policy 2 lets extended-address loads and stores run in user mode
// RULE18: policy 3 lets both instruction kinds run in user mode
// RULE19: disallowed user-mode instruction raises privileged exception
// RULE20: a forbidden special register read returns zero, changes nothing
//
// The placing of the registers and the APB interface to the registers were left to the implementer.
`timescale 1ns/1ps
module mmu_privilege_config (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire mmu_cfg_pkg::spr_req_s spr_req,
  output mmu_cfg_pkg::spr_rsp_s spr_rsp,
  input wire mmu_cfg_pkg::instr_s instr,
  output logic priv_ok,
  input wire mmu_cfg_pkg::xlat_req_s dreq,
  output mmu_cfg_pkg::xlat_rsp_s drsp,
  input wire mmu_cfg_pkg::xlat_req_s ireq,
  output mmu_cfg_pkg::xlat_rsp_s irsp,
  output logic [4:0] exc_enable,
  output logic [4:0] exc_pulse
);
  mmu_cfg_pkg::level_e level;
  mmu_cfg_pkg::access_e acc;
  logic [1:0] policy;
  logic [4:0] zone_cnt;
  logic [3:0] tlb_index_reg;
  logic [7:0] process_id_reg;
  logic [31:0] zone_access_reg;
  logic [4:0] cause;
  mmu_cfg_pkg::tlb_entry_s main_tlb [mmu_cfg_pkg::MAIN_ENTRIES];
  logic [4:0] dfind;
  logic [4:0] ifind;
  mmu_cfg_pkg::tlb_entry_s dmain;
  mmu_cfg_pkg::tlb_entry_s imain;
  mmu_cfg_pkg::tlb_entry_s dent;
  mmu_cfg_pkg::tlb_entry_s ient;
  mmu_cfg_pkg::xlat_rsp_s dsh;
  mmu_cfg_pkg::xlat_rsp_s ish;
  logic [4:0] next_exc;
  logic spr_wr_ok;
  logic spr_rd_ok;
  logic tlb_flush;
  logic bypass;
  logic apb_wr;
  logic apb_rd;
  logic d_user;
  logic d_write;
  logic i_user;
  logic [31:0] next_rdata;

  // Returns {hit, index} of the first valid main entry mapping vpn
  function automatic logic [4:0] find_entry(input logic [21:0] vpn);
    logic [4:0] r;
    r = '0;
    for (int i = mmu_cfg_pkg::MAIN_ENTRIES - 1; i >= 0; i--) begin
      if (main_tlb[i].valid && main_tlb[i].vpn == vpn)
        r = {1'b1, 4'(i)};
    end
    return r;
  endfunction

  function automatic logic rd_allowed(input mmu_cfg_pkg::access_e a,
                                      input mmu_cfg_pkg::spr_sel_e s);
    logic known;
    known = (s <= mmu_cfg_pkg::SPR_ZPR);
    unique case (a)
      mmu_cfg_pkg::ACC_MIN: rd_allowed = 1'b0; // [RULE10]
      mmu_cfg_pkg::ACC_READ: rd_allowed = known; // [RULE11]
      mmu_cfg_pkg::ACC_WRITE:
        rd_allowed = (s == mmu_cfg_pkg::SPR_IDX); // [RULE12]
      mmu_cfg_pkg::ACC_FULL: rd_allowed = known; // [RULE13]
    endcase
  endfunction

  function automatic logic wr_allowed(input mmu_cfg_pkg::access_e a,
                                      input mmu_cfg_pkg::spr_sel_e s);
    logic tlb_reg;
    tlb_reg = (s == mmu_cfg_pkg::SPR_LO) || (s == mmu_cfg_pkg::SPR_HI) ||
              (s == mmu_cfg_pkg::SPR_IDX);
    unique case (a)
      mmu_cfg_pkg::ACC_MIN, mmu_cfg_pkg::ACC_READ:
        wr_allowed = tlb_reg; // [RULE10] [RULE11]
      mmu_cfg_pkg::ACC_WRITE, mmu_cfg_pkg::ACC_FULL:
        wr_allowed = (s <= mmu_cfg_pkg::SPR_ZPR); // [RULE12] [RULE13]
    endcase
  endfunction

  // Zone access check; zones at or above the implemented count use entry rights
  function automatic logic zone_fault(input mmu_cfg_pkg::tlb_entry_s e,
                                      input logic user, input logic wr,
                                      input logic fetch);
    logic [1:0] za;
    logic [4:0] z;
    z = {1'b0, e.zone};
    za = (z < zone_cnt) ? zone_access_reg[2*e.zone +: 2] : 2'h1; // [RULE14]
    if (za == 2'h3 || (za == 2'h2 && !user))
      zone_fault = 1'b0;
    else if (za == 2'h0 && user)
      zone_fault = 1'b1;
    else
      zone_fault = (wr && !e.wr) || (fetch && !e.ex);
  endfunction

  assign apb_wr = psel && penable && pwrite;
  assign apb_rd = psel && !pwrite;
  assign pready = 1'b1;
  assign pslverr = psel && penable && paddr != mmu_cfg_pkg::CTRL_OFS &&
                   paddr != mmu_cfg_pkg::STAT_OFS &&
                   paddr != mmu_cfg_pkg::CAUSE_OFS;

  // Levels below protection have no TLB at all; only addresses pass
  assign bypass = (level == mmu_cfg_pkg::LVL_NONE) ||
                  (level == mmu_cfg_pkg::LVL_USER); // [RULE2]

  always_comb begin
    exc_enable = '0;
    if (level != mmu_cfg_pkg::LVL_NONE)
      exc_enable[mmu_cfg_pkg::EXC_PRIV] = 1'b1; // [RULE5]
    if (!bypass)
      exc_enable = 5'h1f; // [RULE6]
  end

  // Configuration register: level, access, policy and zone count
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      level <= mmu_cfg_pkg::level_e'(mmu_cfg_pkg::LVL_RST); // [RULE1]
      acc <= mmu_cfg_pkg::access_e'(mmu_cfg_pkg::ACC_RST);
      policy <= mmu_cfg_pkg::POL_RST;
      zone_cnt <= mmu_cfg_pkg::ZN_RST;
    end else if (apb_wr && paddr == mmu_cfg_pkg::CTRL_OFS) begin
      level <= mmu_cfg_pkg::level_e'(pwdata[mmu_cfg_pkg::LVL_LSB +: 2]);
      acc <= mmu_cfg_pkg::access_e'(pwdata[mmu_cfg_pkg::ACC_LSB +: 2]);
      policy <= pwdata[mmu_cfg_pkg::POL_LSB +: 2];
      // Counts above the maximum saturate rather than wrap
      if (pwdata[mmu_cfg_pkg::ZN_LSB +: 5] > 5'(mmu_cfg_pkg::MAX_ZONES))
        zone_cnt <= 5'(mmu_cfg_pkg::MAX_ZONES); // [RULE14]
      else
        zone_cnt <= pwdata[mmu_cfg_pkg::ZN_LSB +: 5];
    end
  end

  always_comb begin
    next_rdata = '0;
    unique case (paddr)
      mmu_cfg_pkg::CTRL_OFS: begin
        next_rdata[mmu_cfg_pkg::LVL_LSB +: 2] = level;
        next_rdata[mmu_cfg_pkg::ACC_LSB +: 2] = acc;
        next_rdata[mmu_cfg_pkg::POL_LSB +: 2] = policy;
        next_rdata[mmu_cfg_pkg::ZN_LSB +: 5] = zone_cnt;
      end
      mmu_cfg_pkg::STAT_OFS: begin
        next_rdata[mmu_cfg_pkg::LVL_LSB +: 2] = level;
        next_rdata[mmu_cfg_pkg::STAT_EN_LSB +: 5] = exc_enable;
        next_rdata[mmu_cfg_pkg::STAT_PID_LSB +: 8] = process_id_reg;
        next_rdata[mmu_cfg_pkg::STAT_IDX_LSB +: 4] = tlb_index_reg;
      end
      mmu_cfg_pkg::CAUSE_OFS: next_rdata[4:0] = cause;
      default: next_rdata = '0;
    endcase
  end

  // Read data registered in the setup cycle, stable in the access phase
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      prdata <= '0;
    else if (apb_rd && !penable)
      prdata <= next_rdata;
  end

  // Sticky causes, write one to clear; a new event beats the clear
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      cause <= '0;
    else if (apb_wr && paddr == mmu_cfg_pkg::CAUSE_OFS)
      cause <= (cause & ~pwdata[4:0]) | next_exc;
    else
      cause <= cause | next_exc;
  end

  // Special register moves are accepted only with protection or translation
  assign spr_wr_ok = spr_req.valid && spr_req.write && !bypass &&
                     wr_allowed(acc, spr_req.sel); // [RULE9]
  assign spr_rd_ok = spr_req.valid && !spr_req.write && !bypass &&
                     rd_allowed(acc, spr_req.sel); // [RULE9]
  assign tlb_flush = spr_wr_ok && (spr_req.sel == mmu_cfg_pkg::SPR_LO ||
                                   spr_req.sel == mmu_cfg_pkg::SPR_HI);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tlb_index_reg <= '0;
      process_id_reg <= '0;
      zone_access_reg <= '0;
    end else if (spr_wr_ok) begin
      if (spr_req.sel == mmu_cfg_pkg::SPR_IDX)
        tlb_index_reg <= spr_req.wdata[3:0];
      if (spr_req.sel == mmu_cfg_pkg::SPR_PID)
        process_id_reg <= spr_req.wdata[7:0];
      if (spr_req.sel == mmu_cfg_pkg::SPR_ZPR)
        zone_access_reg <= spr_req.wdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < mmu_cfg_pkg::MAIN_ENTRIES; i++)
        main_tlb[i] <= '0;
    end else if (spr_wr_ok && spr_req.sel == mmu_cfg_pkg::SPR_HI) begin
      main_tlb[tlb_index_reg].vpn <=
        spr_req.wdata[31:mmu_cfg_pkg::PAGE_LSB];
      main_tlb[tlb_index_reg].valid <=
        spr_req.wdata[mmu_cfg_pkg::HI_VALID_BIT];
    end else if (spr_wr_ok && spr_req.sel == mmu_cfg_pkg::SPR_LO) begin
      main_tlb[tlb_index_reg].rpn <=
        spr_req.wdata[31:mmu_cfg_pkg::PAGE_LSB];
      main_tlb[tlb_index_reg].ex <= spr_req.wdata[mmu_cfg_pkg::LO_EX_BIT];
      main_tlb[tlb_index_reg].wr <= spr_req.wdata[mmu_cfg_pkg::LO_WR_BIT];
      main_tlb[tlb_index_reg].zone <=
        spr_req.wdata[mmu_cfg_pkg::LO_ZONE_LSB +: 4];
    end
  end

  // Answer one cycle after the request; forbidden reads give zero
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      spr_rsp <= '0;
    end else begin
      spr_rsp.done <= spr_req.valid;
      spr_rsp.ok <= spr_wr_ok || spr_rd_ok;
      spr_rsp.rdata <= '0; // [RULE20]
      if (spr_rd_ok) begin
        unique case (spr_req.sel)
          mmu_cfg_pkg::SPR_LO:
            spr_rsp.rdata <= {main_tlb[tlb_index_reg].rpn,
                              main_tlb[tlb_index_reg].ex,
                              main_tlb[tlb_index_reg].wr,
                              main_tlb[tlb_index_reg].zone, 4'h0};
          mmu_cfg_pkg::SPR_HI:
            spr_rsp.rdata <= {main_tlb[tlb_index_reg].vpn, 3'h0,
                              main_tlb[tlb_index_reg].valid, 6'h00};
          mmu_cfg_pkg::SPR_IDX: spr_rsp.rdata <= {28'h0, tlb_index_reg};
          mmu_cfg_pkg::SPR_PID: spr_rsp.rdata <= {24'h0, process_id_reg};
          mmu_cfg_pkg::SPR_ZPR: spr_rsp.rdata <= zone_access_reg;
          default: spr_rsp.rdata <= '0;
        endcase
      end
    end
  end

  // User-mode instruction policy; checks are off when disabled
  always_comb begin
    priv_ok = 1'b1;
    if (instr.valid && instr.user && level != mmu_cfg_pkg::LVL_NONE) begin
      unique case (instr.cls)
        mmu_cfg_pkg::CLS_PLAIN: priv_ok = 1'b1;
        mmu_cfg_pkg::CLS_PRIV: priv_ok = 1'b0; // [RULE15]
        mmu_cfg_pkg::CLS_STREAM: priv_ok = policy[0]; // [RULE16] [RULE18]
        mmu_cfg_pkg::CLS_EXT: priv_ok = policy[1]; // [RULE17] [RULE18]
      endcase
    end
  end

  // A process, not an assign, so that TLB writes also wake the lookup
  always_comb begin
    dfind = find_entry(dreq.vaddr[31:mmu_cfg_pkg::PAGE_LSB]);
    ifind = find_entry(ireq.vaddr[31:mmu_cfg_pkg::PAGE_LSB]);
  end
  assign dmain = main_tlb[dfind[3:0]];
  assign imain = main_tlb[ifind[3:0]];

  shadow_tlb #(
    .ENTRIES(mmu_cfg_pkg::DTLB_ENTRIES)
  ) u_dtlb (
    .pclk(pclk),
    .presetn(presetn),
    .flush(tlb_flush),
    .bypass(bypass),
    .translate(level == mmu_cfg_pkg::LVL_VIRT),
    .req(dreq),
    .main_hit(dfind[4]),
    .main_entry(dmain),
    .rsp(dsh),
    .rsp_entry(dent)
  ); // [RULE7] [RULE4]

  shadow_tlb #(
    .ENTRIES(mmu_cfg_pkg::ITLB_ENTRIES)
  ) u_itlb (
    .pclk(pclk),
    .presetn(presetn),
    .flush(tlb_flush),
    .bypass(bypass),
    .translate(level == mmu_cfg_pkg::LVL_VIRT),
    .req(ireq),
    .main_hit(ifind[4]),
    .main_entry(imain),
    .rsp(ish),
    .rsp_entry(ient)
  ); // [RULE8] [RULE4]

  // Request attributes kept for the check made on the answer cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      d_user <= 1'b0;
      d_write <= 1'b0;
      i_user <= 1'b0;
    end else begin
      d_user <= dreq.user;
      d_write <= dreq.write;
      i_user <= ireq.user;
    end
  end

  always_comb begin
    next_exc = '0;
    next_exc[mmu_cfg_pkg::EXC_PRIV] = !priv_ok; // [RULE19]
    if (!bypass) begin
      next_exc[mmu_cfg_pkg::EXC_DMISS] = dsh.miss; // [RULE6]
      next_exc[mmu_cfg_pkg::EXC_IMISS] = ish.miss;
      next_exc[mmu_cfg_pkg::EXC_DSTOR] = dsh.done && !dsh.miss &&
        zone_fault(dent, d_user, d_write, 1'b0); // [RULE3]
      next_exc[mmu_cfg_pkg::EXC_ISTOR] = ish.done && !ish.miss &&
        zone_fault(ient, i_user, 1'b0, 1'b1); // [RULE3]
    end
    next_exc = next_exc & exc_enable;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn)
      exc_pulse <= '0;
    else
      exc_pulse <= next_exc;
  end

  assign drsp = dsh;
  assign irsp = ish;
endmodule

// ==== testbench/mmu_privilege_config_monitor.sv ====
// Concurrent checks on the ports of the MMU configuration unit
`timescale 1ns/1ps
module mmu_privilege_config_monitor (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire mmu_cfg_pkg::spr_req_s spr_req,
  input wire mmu_cfg_pkg::spr_rsp_s spr_rsp,
  input wire mmu_cfg_pkg::instr_s instr,
  input wire logic priv_ok,
  input wire mmu_cfg_pkg::xlat_req_s dreq,
  input wire mmu_cfg_pkg::xlat_rsp_s drsp,
  input wire mmu_cfg_pkg::xlat_req_s ireq,
  input wire mmu_cfg_pkg::xlat_rsp_s irsp,
  input wire logic [4:0] exc_enable,
  input wire logic [4:0] exc_pulse
);
  logic [1:0] lvl;
  logic [1:0] acc;
  logic [1:0] pol;
  logic allow;
  logic exp_ok;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Shadow of the control fields, snooped from completed APB writes
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      lvl <= mmu_cfg_pkg::LVL_RST;
      acc <= mmu_cfg_pkg::ACC_RST;
      pol <= mmu_cfg_pkg::POL_RST;
    end else if (psel && penable && pwrite &&
                 paddr == mmu_cfg_pkg::CTRL_OFS) begin
      lvl <= pwdata[1:0];
      acc <= pwdata[3:2];
      pol <= pwdata[5:4];
    end
  end
  always_comb begin
    if (lvl < 2'h2 || spr_req.sel > 3'h4) allow = 1'b0;
    else if (spr_req.write) allow = acc[1] || spr_req.sel <= 3'h2;
    else if (acc == 2'h2) allow = spr_req.sel == 3'h2;
    else allow = acc != 2'h0;
  end
  always_comb begin
    case (instr.cls)
      mmu_cfg_pkg::CLS_PRIV: exp_ok = 1'b0;
      mmu_cfg_pkg::CLS_STREAM: exp_ok = pol[0];
      mmu_cfg_pkg::CLS_EXT: exp_ok = pol[1];
      default: exp_ok = 1'b1;
    endcase
    if (lvl == 2'h0 || !instr.user) exp_ok = 1'b1;
  end
  sequence s_spr_take;
    spr_req.valid;
  endsequence
  sequence s_refused;
    spr_rsp.done && !spr_rsp.ok;
  endsequence
  property p_exc_off; lvl == 2'h0 |-> exc_enable == 5'h00; endproperty
  property p_exc_user; lvl == 2'h1 |-> exc_enable == 5'h01; endproperty
  property p_exc_mem; lvl[1] |-> exc_enable == 5'h1f; endproperty
  property p_miss_exc;
    drsp.done && drsp.miss |=> exc_pulse[mmu_cfg_pkg::EXC_DMISS];
  endproperty
  property p_priv; instr.valid |-> priv_ok == exp_ok; endproperty
  property p_priv_exc;
    instr.valid && !priv_ok |=> exc_pulse[mmu_cfg_pkg::EXC_PRIV];
  endproperty
  property p_spr_done; s_spr_take |=> spr_rsp.done; endproperty
  property p_gate; s_spr_take |=> spr_rsp.ok == $past(allow); endproperty
  property p_spr_zero;
    s_spr_take ##0 (!spr_req.write && !allow) |=>
      s_refused ##0 spr_rsp.rdata == 32'h0;
  endproperty
  property p_flat;
    dreq.valid && !lvl[1] |=>
      drsp.done && !drsp.miss && drsp.paddr == $past(dreq.vaddr);
  endproperty
  a_exc_off: assert property (p_exc_off)
    else $error("exception enables not clear at level 0");
  a_exc_user: assert property (p_exc_user)
    else $error("level 1 exception enables wrong");
  a_exc_mem: assert property (p_exc_mem)
    else $error("memory exception enables wrong");
  a_miss_exc: assert property (p_miss_exc)
    else $error("data miss gave no miss exception");
  a_priv: assert property (p_priv)
    else $error("user instruction permission wrong");
  a_priv_exc: assert property (p_priv_exc)
    else $error("refused instruction raised no exception");
  a_spr_done: assert property (p_spr_done)
    else $error("special register request not answered");
  a_gate: assert property (p_gate)
    else $error("special register gating wrong");
  a_spr_zero: assert property (p_spr_zero)
    else $error("refused read returned data");
  a_flat: assert property (p_flat)
    else $error("untranslated address changed");
endmodule
bind mmu_privilege_config mmu_privilege_config_monitor u_monitor (
  .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
  .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
  .pready(pready), .pslverr(pslverr), .spr_req(spr_req),
  .spr_rsp(spr_rsp), .instr(instr), .priv_ok(priv_ok), .dreq(dreq),
  .drsp(drsp), .ireq(ireq), .irsp(irsp), .exc_enable(exc_enable),
  .exc_pulse(exc_pulse)
);

// ==== testbench/mmu_privilege_config_bench.sv ====
// Self-checking bench for the MMU configuration unit
`timescale 1ns/1ps
module mmu_privilege_config_bench;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, priv_ok, err, ok;
  logic [4:0] exc_enable, exc_pulse;
  logic [31:0] rd;
  mmu_cfg_pkg::spr_req_s spr_req = '0;
  mmu_cfg_pkg::spr_rsp_s spr_rsp;
  mmu_cfg_pkg::instr_s instr = '0;
  mmu_cfg_pkg::xlat_req_s dreq = '0;
  mmu_cfg_pkg::xlat_req_s ireq = '0;
  mmu_cfg_pkg::xlat_rsp_s drsp, irsp, rsp;
  int miscompares = 0;
  int checked = 0;
  int cycles = 0;
  localparam logic [31:0] VA = {22'h02a, 10'h123};
  always #50 pclk = ~pclk;
  mmu_privilege_config DUT (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .spr_req(spr_req), .spr_rsp(spr_rsp), .instr(instr),
    .priv_ok(priv_ok), .dreq(dreq), .drsp(drsp), .ireq(ireq),
    .irsp(irsp), .exc_enable(exc_enable), .exc_pulse(exc_pulse));
  task automatic check(input string name, input logic [31:0] seen,
                       input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      miscompares++;
      $display("MISMATCH %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic summarize();
    $display("checked %0d miscompares %0d", checked, miscompares);
    if (miscompares == 0 && checked > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      summarize();
    end
  end
  function automatic logic [31:0] ctrl(input logic [1:0] l, a, p,
                                       input logic [4:0] z);
    return {19'h0, z, 2'h0, p, a, l};
  endfunction
  task automatic apb(input logic wr, input logic [7:0] a,
                     input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    #1;
  endtask
  // Special register access; answer sampled once the take edge has landed
  task automatic spr(input logic wr, input logic [2:0] s,
                     input logic [31:0] d);
    @(posedge pclk);
    spr_req <= '{1'b1, wr, mmu_cfg_pkg::spr_sel_e'(s), d};
    @(posedge pclk);
    spr_req.valid <= 1'b0;
    #1;
    ok = spr_rsp.ok;
    rd = spr_rsp.rdata;
  endtask
  // Exception pulses trail the translation answer by one more cycle
  task automatic xl(input logic ins, input logic [31:0] va);
    @(posedge pclk);
    if (ins) ireq <= '{1'b1, 1'b0, 1'b1, va};
    else dreq <= '{1'b1, 1'b0, 1'b1, va};
    @(posedge pclk);
    ireq.valid <= 1'b0;
    dreq.valid <= 1'b0;
    #1;
    rsp = ins ? irsp : drsp;
    @(posedge pclk);
    #1;
  endtask
  task automatic user_instr(input logic [1:0] c, input logic exp);
    @(posedge pclk);
    instr <= '{1'b1, 1'b1, mmu_cfg_pkg::instr_cls_e'(c)};
    #1;
    check("priv_ok", priv_ok, exp);
    @(posedge pclk);
    instr.valid <= 1'b0;
    #1;
    check("priv exc", exc_pulse[mmu_cfg_pkg::EXC_PRIV], !exp);
  endtask
  logic [4:0] en_tab [4] = '{5'h00, 5'h01, 5'h1f, 5'h1f};
  logic pe;
  logic aw [4][6];
  logic ar [4][6];
  initial begin
    aw = '{'{1,1,1,0,0,0}, '{1,1,1,0,0,0}, '{1,1,1,1,1,0}, '{1,1,1,1,1,0}};
    ar = '{'{0,0,0,0,0,0}, '{1,1,1,1,1,0}, '{0,0,1,0,0,0}, '{1,1,1,1,1,0}};
    repeat (8) @(posedge pclk);
    presetn <= 1'b1;
    apb(0, mmu_cfg_pkg::CTRL_OFS, 0);
    check("ctrl reset", rd, 32'h0000100c);
    check("mapped err", {31'h0, err}, 32'h0);
    apb(0, 8'h0c, 0);
    check("unmapped err", {31'h0, err}, 32'h1);
    check("unmapped data", rd, 32'h0);
    for (int l = 0; l < 4; l++) begin
      for (int p = 0; p < 4; p++) begin
        apb(1, mmu_cfg_pkg::CTRL_OFS, ctrl(l, 3, p, 5'h10));
        check("exc_enable", exc_enable, en_tab[l]);
        for (int c = 0; c < 4; c++) begin
          pe = (l == 0) || (c == 0) || (c == 2 && p[0]) || (c == 3 && p[1]);
          user_instr(c, pe);
        end
      end
      apb(0, mmu_cfg_pkg::STAT_OFS, 0);
      check("status en", rd[6:2], en_tab[l]);
      spr(1, 3'h2, 0);
      check("low level spr", ok, l > 1);
    end
    for (int a = 0; a < 4; a++) begin
      apb(1, mmu_cfg_pkg::CTRL_OFS, ctrl(3, a, 0, 5'h10));
      for (int s = 0; s < 6; s++) begin
        spr(1, s, 0);
        check("spr write ok", ok, aw[a][s]);
        spr(0, s, 0);
        check("spr read ok", ok, ar[a][s]);
        if (!ar[a][s]) check("refused read", rd, 32'h0);
      end
      if (a == 3) spr(1, 3'h2, 5);
    end
    apb(1, mmu_cfg_pkg::CTRL_OFS, ctrl(3, 0, 0, 5'h10));
    spr(0, 3'h2, 0);
    check("refused idx", rd, 32'h0);
    apb(1, mmu_cfg_pkg::CTRL_OFS, ctrl(3, 3, 0, 5'h10));
    spr(0, 3'h2, 0);
    check("index kept", rd[3:0], 4'h5);
    apb(1, mmu_cfg_pkg::CTRL_OFS, ctrl(3, 3, 0, 5'h14));
    apb(0, mmu_cfg_pkg::CTRL_OFS, 0);
    check("zone sat", rd[12:8], 5'h10);
    apb(1, mmu_cfg_pkg::CTRL_OFS, ctrl(3, 3, 0, 5'h05));
    apb(0, mmu_cfg_pkg::CTRL_OFS, 0);
    check("zone count", rd[12:8], 5'h05);
    apb(1, mmu_cfg_pkg::CTRL_OFS, ctrl(3, 3, 0, 5'h10));
    spr(1, 3'h2, 0);
    spr(1, 3'h0, {22'h155, 10'h300});
    spr(1, 3'h1, {22'h02a, 10'h040});
    spr(1, 3'h4, 32'hffffffff);
    // Second pass of each kind is served from the shadow copy
    for (int k = 0; k < 4; k++) begin
      xl(k[0], VA);
      check("mapped addr", rsp.paddr, {22'h155, 10'h123});
      check("mapped miss", rsp.miss, 0);
    end
    xl(0, {22'h3ff, 10'h0});
    check("miss flag", rsp.miss, 1);
    check("miss exc", exc_pulse[mmu_cfg_pkg::EXC_DMISS], 1);
    xl(1, {22'h3ff, 10'h0});
    check("imiss exc", exc_pulse[mmu_cfg_pkg::EXC_IMISS], 1);
    apb(0, mmu_cfg_pkg::CAUSE_OFS, 0);
    check("cause", rd, 32'h19);
    apb(1, mmu_cfg_pkg::CAUSE_OFS, 32'h1f);
    apb(0, mmu_cfg_pkg::CAUSE_OFS, 0);
    check("cause clr", rd, 32'h0);
    apb(1, mmu_cfg_pkg::CTRL_OFS, ctrl(2, 3, 0, 5'h10));
    xl(0, VA);
    check("prot addr", rsp.paddr, VA);
    spr(1, 3'h4, 32'h0);
    xl(0, VA);
    check("zone fault", exc_pulse[mmu_cfg_pkg::EXC_DSTOR], 1);
    apb(1, mmu_cfg_pkg::CTRL_OFS, ctrl(0, 3, 0, 5'h10));
    xl(0, VA);
    check("flat addr", rsp.paddr, VA);
    check("flat exc", exc_pulse, 5'h00);
    summarize();
  end
endmodule
